// File: src/buffer_map.svh
`ifndef BUFFER_MAP_SVH
`define BUFFER_MAP_SVH

// ----------------------------------------------------------------
// Widths of the channel and output columns, and the select channel
// ----------------------------------------------------------------
`define CHANNEL_COUNT      25
`define COLUMN_ROWS        14
`define SELECT_CHANNEL     7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define RX_ACTIVE_NS       10
`define RX_ACTIVE_CYCLES   ((`RX_ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Controller register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL_OFFSET    12'h000
`define REG_DATA_OFFSET    12'h004
`define REG_COLA_OFFSET    12'h008
`define REG_COLB_OFFSET    12'h00C

// ----------------------------------------------------------------
// Control register fields and control and data register reset values
// ----------------------------------------------------------------
`define CTRL_RESET_BIT     0
`define CTRL_FANOUT_BIT    1
`define CTRL_BANK_BIT      2
`define CTRL_SECONDARY_BIT 3
`define CTRL_RESET_VALUE   4'h0
`define DATA_RESET_VALUE   25'h0000000

`endif

// File: src/buffer_pkg.sv
package buffer_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [25:1] channel_vec_t;
  typedef logic [14:1] column_t;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_DUAL_A,
    MODE_DUAL_B
  } fanout_mode_t;

  typedef enum logic [1:0] {
    RX_OFF,
    RX_WAKING,
    RX_ON
  } rx_state_t;

endpackage

// File: src/buffer_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface buffer_link_if;
  logic                   resetN;
  logic                   fanoutModeStrap;
  logic                   bankSelectStrap;
  buffer_pkg::channel_vec_t bufferInputs;
  logic                   moduleChipSelectIn;
  logic                   secondaryChipSelectIn;
  buffer_pkg::column_t    registeredOutputsA;
  buffer_pkg::column_t    registeredOutputsB;

  modport device (
    input  resetN,
    input  fanoutModeStrap,
    input  bankSelectStrap,
    input  bufferInputs,
    input  moduleChipSelectIn,
    input  secondaryChipSelectIn,
    output registeredOutputsA,
    output registeredOutputsB
  );

  modport controller (
    output resetN,
    output fanoutModeStrap,
    output bankSelectStrap,
    output bufferInputs,
    output moduleChipSelectIn,
    output secondaryChipSelectIn,
    input  registeredOutputsA,
    input  registeredOutputsB
  );
endinterface

`default_nettype wire

// File: src/registered_buffer.sv
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "buffer_map.svh"

// Behaviour
// - Capture inputs on rising clock, drive outputs
// - Fanout strap selects 25x1 or 14x2
// - Bank strap selects A or B assignment
// - Straps fixed and never changed while running
// - Single mode holds three spare outputs low
// - Async active-low reset clears everything at once
// - Outputs stay low, glitch-free, after release
// - Reset held low until clock stable
// - In reset receivers off, inputs ignored
// - Reset and straps always driven valid
// - Both chip selects high freeze gated outputs
// - Either chip select low updates gated outputs
// - Reset overrides chip-select gating
// - Secondary select grounded disables gating
// - Enable, termination, select channels never frozen
// - Single mode ungated channels 1, 4, 7
// - Dual A ungated channels 1, 4, 7
// - Dual B ungated channels 7, 11, 14
// - Unused inputs ignored, unused outputs low

module registered_buffer (
  // Clock and local reset
  input  wire logic     clk,
  input  wire logic     rst,
  // Link toward controller and memory devices
  buffer_link_if.device link
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic buffer_pkg::fanout_mode_t decodeMode(input logic fanout,
                                                          input logic bank);
    buffer_pkg::fanout_mode_t m;
    m = buffer_pkg::MODE_SINGLE;
    if (fanout) begin
      m = bank ? buffer_pkg::MODE_DUAL_B : buffer_pkg::MODE_DUAL_A;
    end
    return m;
  endfunction

  // Channel carries data in the selected mode
  function automatic logic channelUsed(input buffer_pkg::fanout_mode_t m,
                                       input int unsigned ch);
    logic used;
    used = 1'b0;
    if (m == buffer_pkg::MODE_SINGLE) begin
      used = (ch >= 1) && (ch <= `CHANNEL_COUNT);
    end else begin
      used = (ch >= 1) && (ch <= `COLUMN_ROWS);
    end
    return used;
  endfunction

  // Channel may be frozen by the chip selects
  function automatic logic channelGated(input buffer_pkg::fanout_mode_t m,
                                        input int unsigned ch);
    logic gated;
    gated = 1'b0;
    unique case (m)
      buffer_pkg::MODE_SINGLE: begin
        gated = (ch != 1) && (ch != 4) && (ch != `SELECT_CHANNEL);
      end
      buffer_pkg::MODE_DUAL_A: begin
        gated = (ch != 1) && (ch != 4) && (ch != `SELECT_CHANNEL);
      end
      buffer_pkg::MODE_DUAL_B: begin
        gated = (ch != `SELECT_CHANNEL) && (ch != 11) && (ch != 14);
      end
      default: begin
        gated = 1'b0;
      end
    endcase
    return gated && channelUsed(m, ch);
  endfunction

  // Channel feeding a row of the second output column; 0 means spare
  function automatic int unsigned columnBChannel(input buffer_pkg::fanout_mode_t m,
                                                 input int unsigned row);
    int unsigned ch;
    ch = 0;
    if (m != buffer_pkg::MODE_SINGLE) begin
      ch = row;
    end else if (row == 2 || row == 3) begin
      ch = row + 13;
    end else if (row == 5 || row == 6) begin
      ch = row + 12;
    end else if (row >= 8) begin
      ch = row + 11;
    end else begin
      ch = 0;
    end
    return ch;
  endfunction

  // ----------------------------------------------------------------
  // Mode and input receivers
  // ----------------------------------------------------------------
  // Straps are read live; changing them mid-run is the system's fault
  buffer_pkg::fanout_mode_t mode;
  assign mode = decodeMode(link.fanoutModeStrap, link.bankSelectStrap);

  buffer_pkg::rx_state_t rxState;
  logic [3:0]            rxCount;
  logic                  rxOn;

  // Receivers wake over a fixed time after release; the register itself
  // is live at once, so low inputs keep the outputs low meanwhile
  always_ff @(posedge clk or negedge link.resetN) begin
    if (!link.resetN) begin
      rxState <= buffer_pkg::RX_OFF;
      rxCount <= 4'h0;
    end else if (rst) begin
      rxState <= buffer_pkg::RX_OFF;
      rxCount <= 4'h0;
    end else begin
      unique case (rxState)
        buffer_pkg::RX_OFF: begin
          rxState <= buffer_pkg::RX_WAKING;
          rxCount <= 4'h0;
        end
        buffer_pkg::RX_WAKING: begin
          if (rxCount == 4'(`RX_ACTIVE_CYCLES - 1)) begin
            rxState <= buffer_pkg::RX_ON;
          end else begin
            rxCount <= rxCount + 4'h1;
          end
        end
        buffer_pkg::RX_ON: begin
          rxState <= buffer_pkg::RX_ON;
        end
        // Spare code: fall back to receivers off rather than stick
        default: begin
          rxState <= buffer_pkg::RX_OFF;
        end
      endcase
    end
  end

  assign rxOn = (rxState == buffer_pkg::RX_ON);

  // ----------------------------------------------------------------
  // Input assembly and chip-select gating
  // ----------------------------------------------------------------
  buffer_pkg::channel_vec_t chanIn;
  logic                     freeze;

  // Channel 7 is the module chip select itself; a receiver that is off
  // reads low, which also keeps a floating pin out of the register
  assign chanIn = rxOn ? {link.bufferInputs[25:8], link.moduleChipSelectIn,
                          link.bufferInputs[6:1]}
                       : '0;

  // Only gated rows stop; enable, termination and select rows keep
  // following the bus so the memories never miss a command boundary
  assign freeze = rxOn && link.moduleChipSelectIn
                       && link.secondaryChipSelectIn;

  // ----------------------------------------------------------------
  // Output registers, one generate row per pin row
  // ----------------------------------------------------------------
  buffer_pkg::column_t next_colA;
  buffer_pkg::column_t next_colB;
  buffer_pkg::column_t holdA;
  buffer_pkg::column_t holdB;
  buffer_pkg::column_t colA;
  buffer_pkg::column_t colB;

  for (genvar r = 1; r <= `COLUMN_ROWS; r++) begin : g_row
    int unsigned chB;
    assign chB = columnBChannel(mode, r);

    assign holdA[r] = freeze && channelGated(mode, r);
    assign holdB[r] = freeze && (chB != 0) && channelGated(mode, chB);

    assign next_colA[r] = holdA[r] ? colA[r] : chanIn[r];
    assign next_colB[r] = holdB[r] ? colB[r]
                        : ((chB != 0) ? chanIn[chB] : 1'b0);
  end

  // Reset wins over gating and clears without waiting for a clock
  always_ff @(posedge clk or negedge link.resetN) begin
    if (!link.resetN) begin
      colA <= '0;
      colB <= '0;
    end else if (rst) begin
      colA <= '0;
      colB <= '0;
    end else begin
      colA <= next_colA;
      colB <= next_colB;
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  assign link.registeredOutputsA = colA;
  assign link.registeredOutputsB = colB;

endmodule

`default_nettype wire

// File: src/buffer_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "buffer_map.svh"

module buffer_controller (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // APB slave
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Link toward the buffer
  buffer_link_if.controller link
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0]               ctrl;
  buffer_pkg::channel_vec_t data;
  logic                     writeEn;
  logic                     setupPhase;

  assign pready     = 1'b1;
  assign writeEn    = psel && penable && pwrite;
  assign setupPhase = psel && !penable;

  // Reset field comes up low so the buffer stays in reset at power-up
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `CTRL_RESET_VALUE;
    end else if (writeEn && paddr == `REG_CTRL_OFFSET) begin
      ctrl[`CTRL_RESET_BIT]     <= pwdata[`CTRL_RESET_BIT];
      ctrl[`CTRL_SECONDARY_BIT] <= pwdata[`CTRL_SECONDARY_BIT];
      // Straps move only while the buffer is held in reset
      if (!ctrl[`CTRL_RESET_BIT]) begin
        ctrl[`CTRL_FANOUT_BIT] <= pwdata[`CTRL_FANOUT_BIT];
        ctrl[`CTRL_BANK_BIT]   <= pwdata[`CTRL_BANK_BIT];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data <= `DATA_RESET_VALUE;
    end else if (writeEn && paddr == `REG_DATA_OFFSET) begin
      data <= pwdata[24:0];
    end
  end

  // Read data is registered in the setup cycle, valid in the access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= 1'b0;
      unique case (paddr)
        `REG_CTRL_OFFSET: prdata <= {28'h0000000, ctrl};
        `REG_DATA_OFFSET: prdata <= {7'h00, data};
        `REG_COLA_OFFSET: prdata <= {18'h00000, link.registeredOutputsA};
        `REG_COLB_OFFSET: prdata <= {18'h00000, link.registeredOutputsB};
        default: begin
          prdata  <= 32'h00000000;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Link drive: every pin driven from a flop except input 7, which is tied low; none left floating
  // ----------------------------------------------------------------
  assign link.resetN                = ctrl[`CTRL_RESET_BIT];
  assign link.fanoutModeStrap       = ctrl[`CTRL_FANOUT_BIT];
  assign link.bankSelectStrap       = ctrl[`CTRL_BANK_BIT];
  assign link.secondaryChipSelectIn = ctrl[`CTRL_SECONDARY_BIT];
  assign link.moduleChipSelectIn    = data[`SELECT_CHANNEL];
  assign link.bufferInputs          = {data[25:8], 1'b0, data[6:1]};

endmodule

`default_nettype wire

// File: test/buffer_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module buffer_link_monitor (
  // Clock and reset
  input wire logic                     clk,
  input wire logic                     rst,
  // Link signals
  input wire logic                     resetN,
  input wire logic                     fanoutModeStrap,
  input wire logic                     bankSelectStrap,
  input wire buffer_pkg::channel_vec_t bufferInputs,
  input wire logic                     moduleChipSelectIn,
  input wire logic                     secondaryChipSelectIn,
  input wire buffer_pkg::column_t      registeredOutputsA,
  input wire buffer_pkg::column_t      registeredOutputsB
);
  // ---------------------------------------------
  // Helper logic
  // ---------------------------------------------
  logic [2:0]  cnt;
  logic [25:1] ch;
  logic [14:1] expA;
  logic [14:1] expB;
  logic [14:1] mask;
  logic        frz;

  assign ch   = {bufferInputs[25:8], moduleChipSelectIn, bufferInputs[6:1]};
  assign expA = ch[14:1];
  assign expB = fanoutModeStrap ? ch[14:1]
              : {ch[25:19], 1'b0, ch[18:17], 1'b0, ch[16:15], 1'b0};
  assign mask = (fanoutModeStrap && bankSelectStrap) ? 14'h1BBF : 14'h3FB6;
  assign frz  = moduleChipSelectIn && secondaryChipSelectIn;

  // Receivers need a few edges to wake, so data checks start late
  always_ff @(posedge clk) begin
    if (rst || !resetN) begin
      cnt <= 3'h0;
    end else if (cnt != 3'h7) begin
      cnt <= cnt + 3'h1;
    end
  end

  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_live;
    resetN && cnt >= 3'h5;
  endsequence
  sequence s_frozen;
    s_live ##0 $past(frz);
  endsequence
  sequence s_open;
    s_live ##0 !$past(frz);
  endsequence

  property p_rst_clear;
    disable iff (1'b0) rst |=> (registeredOutputsA == 14'h0000) && (registeredOutputsB == 14'h0000);
  endproperty
  property p_reset_low;
    !resetN |-> (registeredOutputsA | registeredOutputsB) == 14'h0000;
  endproperty
  property p_wake_low;
    resetN && cnt < 3'h3 |-> (registeredOutputsA | registeredOutputsB) == 14'h0000;
  endproperty
  property p_update_a;
    s_open |-> registeredOutputsA == $past(expA);
  endproperty
  property p_update_b;
    s_open |-> registeredOutputsB == $past(expB);
  endproperty
  property p_freeze_a;
    s_frozen |-> (registeredOutputsA & mask) == ($past(registeredOutputsA) & mask);
  endproperty
  property p_freeze_b;
    s_frozen |-> (registeredOutputsB & mask) == ($past(registeredOutputsB) & mask);
  endproperty
  property p_open_rows;
    s_live |-> (registeredOutputsA & ~mask) == ($past(expA) & ~mask);
  endproperty
  property p_spare_low;
    resetN && !fanoutModeStrap |-> !registeredOutputsB[1] && !registeredOutputsB[4] && !registeredOutputsB[7];
  endproperty

  a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by rst");
  a_reset_low: assert property (p_reset_low) else $error("outputs high in reset");
  a_wake_low: assert property (p_wake_low) else $error("glitch while waking");
  a_update_a: assert property (p_update_a) else $error("column A not updated");
  a_update_b: assert property (p_update_b) else $error("column B not updated");
  a_freeze_a: assert property (p_freeze_a) else $error("column A not frozen");
  a_freeze_b: assert property (p_freeze_b) else $error("column B not frozen");
  a_open_rows: assert property (p_open_rows) else $error("ungated row frozen");
  a_spare_low: assert property (p_spare_low) else $error("spare output high");
endmodule

`default_nettype wire

// File: test/tb_configurable_registered_buffer.sv
`timescale 1ns/1ps
`default_nettype none
`include "buffer_map.svh"

module tb_configurable_registered_buffer;
  logic        clk;
  logic        rst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic [31:0] rd;
  logic [31:0] ctrl;
  logic [14:1] expA;
  logic [14:1] expB;
  int          errorCnt;
  int          comparisons;

  buffer_link_if linkBus ();
  buffer_controller buffer_controller_inst (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .link(linkBus));
  registered_buffer registered_buffer_inst (.clk(clk), .rst(rst), .link(linkBus));
  buffer_link_monitor buffer_link_monitor_inst (.clk(clk), .rst(rst), .resetN(linkBus.resetN),
    .fanoutModeStrap(linkBus.fanoutModeStrap), .bankSelectStrap(linkBus.bankSelectStrap),
    .bufferInputs(linkBus.bufferInputs), .moduleChipSelectIn(linkBus.moduleChipSelectIn),
    .secondaryChipSelectIn(linkBus.secondaryChipSelectIn),
    .registeredOutputsA(linkBus.registeredOutputsA),
    .registeredOutputsB(linkBus.registeredOutputsB));

  // ---------------------------------------------
  // Bus and checking tasks
  // ---------------------------------------------
  always #5 clk = ~clk;

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Expected columns follow the freeze mask of the mode in use
  task automatic put(input int m, input logic [31:0] d, input logic sec);
    logic [14:1] na;
    logic [14:1] nb;
    logic [14:1] mk;
    na = d[13:0];
    nb = (m == 0) ? {d[24:18], 1'b0, d[17:16], 1'b0, d[15:14], 1'b0} : d[13:0];
    mk = (m == 2) ? 14'h1BBF : 14'h3FB6;
    apb(1'b1, `REG_DATA_OFFSET, d);
    if (sec && d[6]) begin
      expA = (expA & mk) | (na & ~mk);
      expB = (expB & mk) | (nb & ~mk);
    end else begin
      expA = na;
      expB = nb;
    end
    apb(1'b0, `REG_COLA_OFFSET, 32'h0);
    check("column A", rd, {18'h0, expA});
    apb(1'b0, `REG_COLB_OFFSET, 32'h0);
    check("column B", rd, {18'h0, expB});
    check("wire A", {18'h0, linkBus.registeredOutputsA}, {18'h0, expA});
  endtask

  task automatic report_and_stop();
    if (errorCnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial begin
    repeat (3000) @(posedge clk);
    errorCnt++;
    report_and_stop();
  end

  initial begin
    logic [31:0] modes [3];
    modes = '{32'h1, 32'h3, 32'h7};
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    errorCnt = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `REG_CTRL_OFFSET, 32'h0);
    check("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped error", {31'h0, pslverr}, 32'h1);
    for (int m = 0; m < 3; m++) begin
      ctrl = modes[m] | 32'h8;
      expA = 14'h0000;
      expB = 14'h0000;
      apb(1'b1, `REG_CTRL_OFFSET, 32'h0);
      apb(1'b1, `REG_DATA_OFFSET, 32'h0);
      apb(1'b1, `REG_CTRL_OFFSET, ctrl);
      // Strap flop updates at the write edge; look once it has settled
      @(negedge clk);
      check("fanout strap", {31'h0, linkBus.fanoutModeStrap}, {31'h0, m != 0});
      put(m, 32'h0, 1'b1);
      put(m, 32'h01555515, 1'b1);
      put(m, 32'h00AAAAEA, 1'b1);
      // Straps must not move while running, so only the select bit lands
      apb(1'b1, `REG_CTRL_OFFSET, (ctrl ^ 32'h6) & ~32'h8);
      apb(1'b0, `REG_CTRL_OFFSET, 32'h0);
      check("ctrl lock", rd, ctrl & ~32'h8);
      put(m, 32'h00AAAAEA, 1'b0);
      apb(1'b1, `REG_CTRL_OFFSET, 32'h0);
      apb(1'b0, `REG_COLA_OFFSET, 32'h0);
      check("column A reset", rd, 32'h0);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
